// >>> verilog/aip_ascii_input.sv
// ASCII input template parser with register port and result output
`timescale 1ns/1ps

module aip_ascii_input
  import aip_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = AIP_TIMEOUT_CYC
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  rx_valid_i,
  input  wire logic [7:0]            rx_char_i,
  input  wire logic [AIP_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  output logic                       res_valid_o,
  output aip_result_t                res_o,
  output logic                       busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Control character decode
  function automatic logic is_ctrl(input logic [7:0] c);
    is_ctrl = (c < 8'h20) || (c == 8'h7F);
  endfunction : is_ctrl

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  aip_tmpl_t                 tmpl;
  logic      [7:0]           term_char;
  logic                      term_en;
  aip_dest_t                 dest_sel;
  aip_state_t                state;
  logic      [AIP_TMR_W-1:0] timer;
  logic      [7:0]           pre_cnt;
  logic      [7:0]           n_cnt;
  logic      [7:0]           str_cnt;
  logic      [7:0]           fld_mem [AIP_FIELD_N];
  logic      [7:0]           eff_len;
  logic      [7:0]           keep;
  logic      [7:0]           next_len;
  logic                      term_act;
  logic                      term_hit;
  logic                      timeout_hit;
  logic                      end_str;
  logic                      acc;
  logic                      skipping;
  logic                      fld_we;
  logic      [7:0]           fofs;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tmpl      <= '{post: AIP_POST_RST, len: AIP_LEN_RST, pre: AIP_PRE_RST};
      term_char <= AIP_TERM_RST;
      term_en   <= AIP_TEN_RST;
      dest_sel  <= AIP_DST_FIRST_ID;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        AIP_TMPL_OFS: begin
          tmpl.pre  <= reg_wdata_i[AIP_PRE_LSB+:8];
          tmpl.len  <= reg_wdata_i[AIP_LEN_LSB+:8];
          tmpl.post <= reg_wdata_i[AIP_POST_LSB+:8];
        end
        AIP_TERM_OFS: begin
          term_char <= reg_wdata_i[7:0];
          term_en   <= reg_wdata_i[AIP_TEN_BIT];
        end
        AIP_DEST_OFS: begin
          dest_sel  <= aip_dest_t'(reg_wdata_i[2:0]);
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // String end detection
  always_comb begin
    term_act    = term_en && is_ctrl(term_char);
    term_hit    = rx_valid_i && term_act && (rx_char_i == term_char);
    timeout_hit = (state == AIP_ST_ACTIVE) && !rx_valid_i &&
                  (timer == AIP_TMR_W'(TIMEOUT_CYC - 1));
    end_str     = term_hit || timeout_hit;
    acc         = rx_valid_i && !term_hit;
    skipping    = pre_cnt < tmpl.pre;
    eff_len     = (tmpl.len < AIP_FIELD_MAX) ? tmpl.len : AIP_FIELD_MAX;
    fld_we      = acc && !skipping && (n_cnt < eff_len);
    keep        = (n_cnt > tmpl.post) ? 8'(n_cnt - tmpl.post) : 8'h00;
    next_len    = (keep < eff_len) ? keep : eff_len;
  end

  ////////////////////////////////////////////////////////////////////////////
  // String state
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= AIP_ST_IDLE;
    end else begin
      unique case (state)
        AIP_ST_IDLE: begin
          if (acc) begin
            state <= AIP_ST_ACTIVE;
          end
        end
        AIP_ST_ACTIVE: begin
          if (end_str) begin
            state <= AIP_ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inter-character timer
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      timer <= '0;
    end else if (rx_valid_i || end_str || state == AIP_ST_IDLE) begin
      timer <= '0;
    end else begin
      timer <= timer + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preamble skip and field collection
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pre_cnt <= 8'h00;
      n_cnt   <= 8'h00;
    end else if (end_str) begin
      pre_cnt <= 8'h00;
      n_cnt   <= 8'h00;
    end else if (acc) begin
      if (skipping) begin
        pre_cnt <= pre_cnt + 8'h01;
      end else if (n_cnt != 8'hFF) begin
        n_cnt   <= n_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (fld_we) begin
      fld_mem[n_cnt[4:0]] <= rx_char_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result hand-over
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      res_valid_o <= 1'b0;
    end else begin
      res_valid_o <= end_str;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      res_o   <= '0;
      str_cnt <= 8'h00;
    end else if (end_str) begin
      res_o.dest   <= dest_sel;
      res_o.lookup <= (dest_sel == AIP_DST_TARE_ID) ||
                      (dest_sel == AIP_DST_TARGET_ID);
      res_o.len    <= next_len;
      for (int i = 0; i < AIP_FIELD_N; i++) begin
        res_o.data[i] <= (8'(i) < next_len) ? fld_mem[i] : 8'h00;
      end
      str_cnt <= str_cnt + 8'h01;
    end
  end

  assign busy_o = (state == AIP_ST_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  assign fofs = 8'(reg_addr_i - AIP_FIELD_OFS);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_addr_i >= AIP_FIELD_OFS && reg_addr_i < AIP_FIELD_END) begin
        reg_rdata_o[7:0] <= res_o.data[fofs[6:2]];
      end else begin
        unique case (reg_addr_i)
          AIP_TMPL_OFS: begin
            reg_rdata_o[23:0] <= tmpl;
          end
          AIP_TERM_OFS: begin
            reg_rdata_o[7:0]         <= term_char;
            reg_rdata_o[AIP_TEN_BIT] <= term_en;
          end
          AIP_DEST_OFS: begin
            reg_rdata_o[2:0] <= dest_sel;
          end
          AIP_STAT_OFS: begin
            reg_rdata_o[7:0]            <= res_o.len;
            reg_rdata_o[AIP_BUSY_BIT]   <= busy_o;
            reg_rdata_o[AIP_CNT_LSB+:8] <= str_cnt;
          end
          default: begin
          end
        endcase
      end
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence term_seen_s;
    term_hit;
  endsequence

  sequence handed_over_s;
    ##1 res_valid_o ##1 (!res_valid_o || $past(term_hit));
  endsequence

  sequence quiet_gap_s;
    (state == AIP_ST_ACTIVE) && !rx_valid_i &&
    (timer == AIP_TMR_W'(TIMEOUT_CYC - 1));
  endsequence

  term_end_a: assert property (term_seen_s |-> handed_over_s)
    else $error("terminator did not hand over the field");

  ctrl_term_a: assert property (
    rx_valid_i && term_en && is_ctrl(term_char) && rx_char_i == term_char
    |=> res_valid_o && state == AIP_ST_IDLE)
    else $error("control character terminator ignored");

  gap_end_a: assert property (quiet_gap_s |-> handed_over_s)
    else $error("timeout did not end the string");

  no_term_a: assert property (
    state == AIP_ST_ACTIVE && rx_valid_i && !term_en
    |=> state == AIP_ST_ACTIVE && timer == '0)
    else $error("string ended without a timeout");

  pre_skip_a: assert property (
    acc && !end_str && pre_cnt < tmpl.pre
    |=> n_cnt == $past(n_cnt) && pre_cnt == $past(pre_cnt) + 8'h01)
    else $error("leading character was collected");

  len_max_a: assert property (
    res_valid_o |-> res_o.len <= $past(eff_len))
    else $error("field longer than data length");

  post_strip_a: assert property (
    end_str |=> res_o.len == 8'h00 ||
    res_o.len + $past(tmpl.post) <= $past(n_cnt))
    else $error("trailing characters not stripped");

  full_drop_a: assert property (
    acc && !skipping && n_cnt >= eff_len && !end_str
    |-> !fld_we ##1 n_cnt >= eff_len)
    else $error("character stored into a full field");

  restart_a: assert property (
    res_valid_o |-> pre_cnt == 8'h00 && n_cnt == 8'h00 && timer == '0)
    else $error("collection state not cleared");

  dest_key_a: assert property (
    res_valid_o |-> res_o.dest == $past(dest_sel) &&
    res_o.lookup == (res_o.dest inside {AIP_DST_TARE_ID,
                                        AIP_DST_TARGET_ID}))
    else $error("wrong destination or look-up flag");

endmodule : aip_ascii_input

// >>> verilog/aip_pkg.sv
// Constants, types and field layouts of the ASCII input template parser
package aip_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          AIP_ADDR_W    = 8;
  localparam logic [7:0]  AIP_TMPL_OFS  = 8'h00;
  localparam logic [7:0]  AIP_TERM_OFS  = 8'h04;
  localparam logic [7:0]  AIP_DEST_OFS  = 8'h08;
  localparam logic [7:0]  AIP_STAT_OFS  = 8'h0C;
  localparam logic [7:0]  AIP_FIELD_OFS = 8'h40;
  localparam logic [7:0]  AIP_FIELD_END = 8'hC0;

  // Field positions
  localparam int          AIP_PRE_LSB   = 0;
  localparam int          AIP_LEN_LSB   = 8;
  localparam int          AIP_POST_LSB  = 16;
  localparam int          AIP_TEN_BIT   = 8;
  localparam int          AIP_BUSY_BIT  = 8;
  localparam int          AIP_CNT_LSB   = 16;

  // Values after reset
  localparam logic [7:0]  AIP_PRE_RST   = 8'h00;
  localparam logic [7:0]  AIP_LEN_RST   = 8'h20;
  localparam logic [7:0]  AIP_POST_RST  = 8'h00;
  localparam logic [7:0]  AIP_TERM_RST  = 8'h0D;
  localparam logic        AIP_TEN_RST   = 1'b1;

  // Field store
  localparam int          AIP_FIELD_N   = 32;
  localparam logic [7:0]  AIP_FIELD_MAX = 8'(AIP_FIELD_N);

  // Inter-character timeout
  localparam int unsigned AIP_TIMEOUT_MS  = 1000;
  localparam int unsigned AIP_CLK_KHZ     = 250000;
  localparam int unsigned AIP_TIMEOUT_CYC = AIP_TIMEOUT_MS * AIP_CLK_KHZ;
  localparam int          AIP_TMR_W       = 28;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    AIP_DST_FIRST_ID   = 3'h0,
    AIP_DST_KEYPAD     = 3'h1,
    AIP_DST_TARE       = 3'h2,
    AIP_DST_TARE_ID    = 3'h3,
    AIP_DST_TARGET_ID  = 3'h4,
    AIP_DST_FILL_ID    = 3'h5,
    AIP_DST_ACT_TARGET = 3'h6
  } aip_dest_t;

  typedef enum logic [0:0] {
    AIP_ST_IDLE   = 1'h0,
    AIP_ST_ACTIVE = 1'h1
  } aip_state_t;

  typedef struct packed {
    logic [7:0] post;
    logic [7:0] len;
    logic [7:0] pre;
  } aip_tmpl_t;

  typedef struct packed {
    aip_dest_t                         dest;
    logic                              lookup;
    logic [7:0]                        len;
    logic [AIP_FIELD_N-1:0][7:0]       data;
  } aip_result_t;

endpackage : aip_pkg

// >>> dv/aip_scanner_model.sv
// Model of the serial ASCII device that feeds the parser
`timescale 1ns/1ps

module aip_scanner_model (
  input  wire logic       core_clk_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_char_o
);

  initial begin
    rx_valid_o = 1'b0;
    rx_char_o  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One string, with gap idle cycles after each character
  // Idle line shows the inverse of the last character, never a held value
  task automatic send(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge core_clk_i);
      rx_valid_o <= 1'b1;
      rx_char_o  <= s[i];
      repeat (gap) begin
        @(posedge core_clk_i);
        rx_valid_o <= 1'b0;
        rx_char_o  <= ~s[i];
      end
    end
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o  <= ~s[s.len()-1];
  endtask : send

endmodule : aip_scanner_model

// >>> dv/test_ascii_input_template_parser.sv
// Self-checking bench of the ASCII input template parser
`timescale 1ns/1ps

module test_ascii_input_template_parser
  import aip_pkg::*;
();

  localparam int TMO = 50;

  logic        clk;
  logic        rst_n;
  logic        rx_valid;
  logic [7:0]  rx_char;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        res_valid;
  aip_result_t res;
  logic        busy;
  int          n_errors;
  int          n_checks;

  aip_ascii_input #(.TIMEOUT_CYC(TMO)) dut (
    .core_clk_i  (clk),
    .rst_n_i     (rst_n),
    .rx_valid_i  (rx_valid),
    .rx_char_i   (rx_char),
    .reg_addr_i  (addr),
    .reg_wdata_i (wdata),
    .reg_wr_i    (wr),
    .reg_rd_i    (rd),
    .reg_rdata_o (rdata),
    .res_valid_o (res_valid),
    .res_o       (res),
    .busy_o      (busy)
  );

  aip_scanner_model u_src (
    .core_clk_i (clk),
    .rx_valid_o (rx_valid),
    .rx_char_o  (rx_char)
  );

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask : rchk

  task automatic cfg(input logic [7:0] pre, len, post, term,
                     input logic en, input logic [2:0] dst);
    reg_wr(AIP_TMPL_OFS, {8'h00, post, len, pre});
    reg_wr(AIP_TERM_OFS, {23'h000000, en, term});
    reg_wr(AIP_DEST_OFS, {29'h00000000, dst});
  endtask : cfg

  task automatic wait_res(input int exp_n);
    int n;
    #1;
    for (n = 0; n < 400 && res_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (res_valid !== 1'b1) begin
      n_errors++;
      end_sim();
    end else begin
      chk("latency", exp_n, n);
      chk("busy", 32'h0, busy);
    end
  endtask : wait_res

  task automatic chk_field(input string s);
    chk("len", s.len(), res.len);
    for (int i = 0; i < AIP_FIELD_N; i++) begin
      chk("byte", (i < s.len()) ? s[i] : 8'h00, res.data[i]);
    end
  endtask : chk_field

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("res_valid", 32'h0, res_valid);
    rchk(AIP_TMPL_OFS, 32'h00002000);
    rchk(AIP_TERM_OFS, 32'h0000010D);
    rchk(AIP_DEST_OFS, 32'h00000000);
    rchk(AIP_STAT_OFS, 32'h00000000);
    rchk(8'h10, 32'h00000000);
  endtask : t_reset

  task automatic t_template();
    cfg(8'h02, 8'h05, 8'h00, 8'h0D, 1'b1, AIP_DST_TARE);
    u_src.send("\002P001.5 kg\015", 0);
    wait_res(0);
    chk_field("001.5");
    chk("dest", AIP_DST_TARE, res.dest);
    chk("lookup", 32'h0, res.lookup);
    rchk(AIP_FIELD_OFS + 8'h10, 32'h00000035);
    rchk(AIP_FIELD_OFS + 8'h14, 32'h00000000);
    rchk(AIP_STAT_OFS, 32'h00010005);
  endtask : t_template

  task automatic t_post();
    cfg(8'h02, 8'h08, 8'h03, 8'h0D, 1'b1, AIP_DST_TARE);
    u_src.send("\002P001.5 kg\015", 0);
    wait_res(0);
    chk_field("001.5");
    cfg(8'h02, 8'h03, 8'h03, 8'h0D, 1'b1, AIP_DST_TARE);
    u_src.send("\002P001.5 kg\015", 0);
    wait_res(0);
    chk_field("001");
  endtask : t_post

  task automatic t_timeout();
    cfg(8'h00, 8'h20, 8'h00, 8'h0D, 1'b0, AIP_DST_FIRST_ID);
    u_src.send("A\015", 20);
    chk("busy", 32'h1, busy);
    wait_res(TMO - 20);
    chk_field("A\015");
  endtask : t_timeout

  task automatic t_dest();
    for (int d = 0; d < 7; d++) begin
      cfg(8'h00, 8'h20, 8'h00, 8'h03, 1'b1, d[2:0]);
      u_src.send("X\003", 0);
      wait_res(0);
      chk("dest", d, res.dest);
      chk("lookup", (d == 3 || d == 4), res.lookup);
      chk_field("X");
    end
  endtask : t_dest

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk      = 1'b0;
    rst_n    = 1'b0;
    addr     = 8'h00;
    wdata    = 32'h00000000;
    wr       = 1'b0;
    rd       = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_template();
    t_post();
    t_timeout();
    t_dest();
    end_sim();
  end

endmodule : test_ascii_input_template_parser
